//--- design/bbc_pkg.sv
// constants, field layout and enumerations of the boiler bivalent control block
// assumes a single 250 MHz clock and a classic wishbone register slave

package bbc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned SEC_TICK_S    = 1;
  localparam int unsigned SEC_CYCLES    = CLK_HZ * SEC_TICK_S;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned QUAL_MIN      = 5;
  localparam int unsigned HOLD_MIN      = 30;
  localparam logic [15:0] MIN_S         = 16'(SEC_PER_MIN);
  localparam logic [15:0] QUAL_S        = 16'(QUAL_MIN * SEC_PER_MIN);
  localparam logic [15:0] HOLD_S        = 16'(HOLD_MIN * SEC_PER_MIN);

  //////////////////////////////////////////////////////////////////////////////
  // temperatures, whole degrees celsius, two's complement
  localparam logic [7:0]  TH_MIN        = 8'hF1;
  localparam logic [7:0]  TH_MAX        = 8'h0F;
  localparam logic [9:0]  HYST_UP       = 10'h002;
  localparam logic [9:0]  HYST_HEAT     = 10'h3FE;
  localparam logic [7:0]  OVER_TEMP     = 8'h55;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_THRESH   = 8'h04;
  localparam logic [7:0]  ADDR_HEAT_SET = 8'h08;
  localparam logic [7:0]  ADDR_DELAY    = 8'h0C;
  localparam logic [7:0]  ADDR_TEMPS    = 8'h10;
  localparam logic [7:0]  ADDR_WATER    = 8'h14;
  localparam logic [7:0]  ADDR_STATUS   = 8'h18;

  // reset values
  localparam logic [10:0] CTRL_RST      = 11'h000;
  localparam logic [7:0]  THRESH_RST    = 8'h00;
  localparam logic [15:0] HEAT_SET_RST  = 16'h0000;
  localparam logic [23:0] DELAY_RST     = 24'h000000;
  localparam logic [23:0] TEMPS_RST     = 24'h000000;
  localparam logic [31:0] WATER_RST     = 32'h00000000;

  // control field positions
  localparam int unsigned CTRL_PAT_BIT  = 0;
  localparam int unsigned CTRL_SUB_LSB  = 1;
  localparam int unsigned CTRL_EXT_BIT  = 3;
  localparam int unsigned CTRL_OPON_BIT = 4;
  localparam int unsigned CTRL_RUN_LSB  = 5;
  localparam int unsigned CTRL_DIR_LSB  = 8;
  localparam int unsigned CTRL_BUF_BIT  = 10;

  //////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [1:0] {
    SUB_ALT = 2'h0,
    SUB_PAR = 2'h1,
    SUB_ADV = 2'h2
  } bbc_sub_t;

  typedef enum logic [2:0] {
    RUN_HEAT      = 3'h0,
    RUN_TANK      = 3'h1,
    RUN_HEAT_TANK = 3'h2,
    RUN_COOL      = 3'h3,
    RUN_COOL_TANK = 3'h4
  } bbc_run_t;

  localparam logic [1:0]  DIR_HEAT_BIT  = 2'h1;
  localparam logic [1:0]  DIR_DHW_BIT   = 2'h2;

  typedef enum logic [1:0] {
    PRH_IDLE = 2'b01,
    PRH_HOLD = 2'b10
  } bbc_prh_t;

endpackage : bbc_pkg

//--- design/bbc_pin_sync.sv
// three-stage synchroniser for pin inputs with agreement filter
// assumes a reset already synchronised to i_ref_clk

module bbc_pin_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] lvl;
  } bbc_sync_t;

  bbc_sync_t q;
  bbc_sync_t d;

  //////////////////////////////////////////////////////////////////////////////
  // a bit changes only once the second and third stages agree
  always_comb begin
    d     = q;
    d.ff1 = i_pin;
    d.ff2 = q.ff1;
    d.ff3 = q.ff2;
    d.lvl = (~(q.ff2 ^ q.ff3) & q.ff3) | ((q.ff2 ^ q.ff3) & q.lvl);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_level = q.lvl;

endmodule : bbc_pin_sync

//--- design/bbc_hold_timer.sv
// qualifies a condition that must hold continuously for a number of seconds
// assumes a one-cycle seconds tick on the same clock

module bbc_hold_timer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_tick,
  input  wire logic        i_cond,
  input  wire logic [15:0] i_limit_s,
  output logic             o_done
);

  typedef struct packed {
    logic [15:0] cnt;
  } bbc_tmr_t;

  bbc_tmr_t q;
  bbc_tmr_t d;

  //////////////////////////////////////////////////////////////////////////////
  // count saturates; any break in the condition restarts it
  always_comb begin
    d = q;
    if (!i_cond) begin
      d.cnt = 16'h0000;
    end else if (i_tick && (q.cnt != 16'hFFFF)) begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_done = i_cond && (q.cnt >= i_limit_s);

endmodule : bbc_hold_timer

//--- design/bbc_boiler_ctrl.sv
// boiler bivalent decision logic with wishbone register file
// assumes classic wishbone master on i_ref_clk; grid and valve inputs come from pins
//
// How it works
// - select automatic or grid-signal pattern
// - outdoor threshold clamped to -15..15 C
// - alternative sub-mode runs one heat source
// - alternative: cold and allowed, boiler on, pumps off
// - alternative: warm or prohibited, boiler off, pumps on
// - external pump follows boiler when enabled
// - parallel: heat pump runs, boiler hysteresis
// - advanced heat: all conditions turn boiler on
// - advanced heat: any condition turns boiler off
// - advanced tank: all conditions turn boiler on
// - advanced tank: any condition turns boiler off
// - direction, offsets, delays and tank delay settings
// - grid bits drive heat pump and boiler
// - grid input removed from default function
// - grid pattern honours external pump enable
// - prohibit after 85 C for five minutes
// - prohibit clears thirty minutes after start if no water reading is still qualified hot
// - only an on/off boiler request leaves
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.

module bbc_boiler_ctrl #(
  parameter int unsigned P_SEC_CYCLES = bbc_pkg::SEC_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [1:0]  i_grid_signal_input,
  input  wire logic        i_valve_tank,
  output logic             o_wb_ack,
  output logic      [31:0] o_wb_dat,
  output logic             o_boiler_on,
  output logic             o_heat_pump_en,
  output logic             o_water_pump_en,
  output logic             o_ext_pump_on,
  output logic             o_prohibit,
  output logic      [1:0]  o_grid_default
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdat;
    logic [10:0]       ctrl;
    logic [7:0]        thresh;
    logic [15:0]       heat_set;
    logic [23:0]       delay_set;
    logic [23:0]       temps;
    logic [31:0]       water;
    logic [27:0]       sec_cnt;
    logic              tick;
    bbc_pkg::bbc_prh_t prh_st;
    logic [15:0]       hold_cnt;
    logic              prohibit;
    logic              boiler;
    logic              hp_en;
    logic              wp_en;
    logic              ext_on;
    logic [1:0]        grid_dflt;
  } bbc_state_t;

  bbc_state_t q;
  bbc_state_t d;

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [2:0]  pins;
  logic [1:0]  grid;
  logic        valve_tank;
  logic        wb_hit;
  logic        wb_wr;
  logic        pat_grid;
  logic [1:0]  sub;
  logic        ext_en;
  logic        op_on;
  logic [2:0]  run;
  logic [1:0]  dir;
  logic        buf_en;
  logic [9:0]  od;
  logic [9:0]  th;
  logic [9:0]  buf_t;
  logic [9:0]  tgt;
  logic        below;
  logic        above_up;
  logic        above_heat;
  logic        start_cond;
  logic        stop_cond;
  logic        start_done;
  logic        stop_done;
  logic        tank_done;
  logic [3:0]  hot;
  logic [3:0]  hot_done;
  logic        any_hot;
  logic        active;
  logic        heat_side;
  logic        on_c;
  logic        off_c;
  logic        boiler_nxt;
  logic [31:0] status;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] bbc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : bbc_merge

  function automatic logic [9:0] bbc_sx(input logic [7:0] v);
    return {{2{v[7]}}, v};
  endfunction : bbc_sx

  function automatic logic [7:0] bbc_clamp(input logic [7:0] v);
    if ($signed(v) < $signed(bbc_pkg::TH_MIN)) begin
      return bbc_pkg::TH_MIN;
    end else if ($signed(v) > $signed(bbc_pkg::TH_MAX)) begin
      return bbc_pkg::TH_MAX;
    end
    return v;
  endfunction : bbc_clamp

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // pin inputs
  bbc_pin_sync #(
    .W (3)
  ) u_pins (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_pin     ({i_valve_tank, i_grid_signal_input}),
    .o_level   (pins)
  );

  assign grid       = pins[1:0];
  assign valve_tank = pins[2];

  //////////////////////////////////////////////////////////////////////////////
  // settings
  assign pat_grid = q.ctrl[bbc_pkg::CTRL_PAT_BIT];
  assign sub      = q.ctrl[bbc_pkg::CTRL_SUB_LSB +: 2];
  assign ext_en   = q.ctrl[bbc_pkg::CTRL_EXT_BIT];
  assign op_on    = q.ctrl[bbc_pkg::CTRL_OPON_BIT];
  assign run      = q.ctrl[bbc_pkg::CTRL_RUN_LSB +: 3];
  assign dir      = q.ctrl[bbc_pkg::CTRL_DIR_LSB +: 2];
  assign buf_en   = q.ctrl[bbc_pkg::CTRL_BUF_BIT];

  assign od    = bbc_sx(q.temps[7:0]);
  assign buf_t = bbc_sx(q.temps[15:8]);
  assign tgt   = bbc_sx(q.temps[23:16]);
  assign th    = bbc_sx(q.thresh);

  assign below      = $signed(od) < $signed(th);
  assign above_up   = $signed(od) > $signed(th + bbc_pkg::HYST_UP);
  assign above_heat = $signed(od) > $signed(th + bbc_pkg::HYST_HEAT);
  assign start_cond = $signed(buf_t) < $signed(tgt + bbc_sx(q.heat_set[7:0]));
  assign stop_cond  = $signed(buf_t) > $signed(tgt + bbc_sx(q.heat_set[15:8]));

  //////////////////////////////////////////////////////////////////////////////
  // delay qualifiers, settings in minutes
  bbc_hold_timer u_start_tmr (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_tick    (q.tick),
    .i_cond    (start_cond),
    .i_limit_s (16'(q.delay_set[7:0]) * bbc_pkg::MIN_S),
    .o_done    (start_done)
  );

  bbc_hold_timer u_stop_tmr (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_tick    (q.tick),
    .i_cond    (stop_cond),
    .i_limit_s (16'(q.delay_set[15:8]) * bbc_pkg::MIN_S),
    .o_done    (stop_done)
  );

  bbc_hold_timer u_tank_tmr (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_tick    (q.tick),
    .i_cond    (valve_tank),
    .i_limit_s (16'(q.delay_set[23:16]) * bbc_pkg::MIN_S),
    .o_done    (tank_done)
  );

  // outlet, inlet, zone 1, zone 2 each qualified on their own
  for (genvar g = 0; g < 4; g++) begin : g_hot
    assign hot[g] = q.water[g*8 +: 8] >= bbc_pkg::OVER_TEMP;
    bbc_hold_timer u_hot_tmr (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (rst_n),
      .i_ce      (i_ce),
      .i_tick    (q.tick),
      .i_cond    (hot[g]),
      .i_limit_s (bbc_pkg::QUAL_S),
      .o_done    (hot_done[g])
    );
  end

  assign any_hot = |hot_done;

  //////////////////////////////////////////////////////////////////////////////
  // decision terms
  assign active    = op_on && ((run == bbc_pkg::RUN_HEAT) || (run == bbc_pkg::RUN_TANK) ||
                               (run == bbc_pkg::RUN_HEAT_TANK));
  assign heat_side = (run == bbc_pkg::RUN_HEAT) ||
                     ((run == bbc_pkg::RUN_HEAT_TANK) && !valve_tank);

  always_comb begin
    if (sub == bbc_pkg::SUB_ADV) begin
      if (heat_side) begin
        on_c  = below && start_done && !valve_tank && dir[0] && buf_en &&
                !q.prohibit;
        off_c = above_heat || stop_done || valve_tank || q.prohibit;
      end else begin
        on_c  = below && tank_done && dir[1] && !q.prohibit;
        off_c = above_up || !valve_tank || q.prohibit;
      end
    end else begin
      on_c  = below && !q.prohibit;
      off_c = above_up || q.prohibit;
    end
  end

  assign boiler_nxt = off_c ? 1'b0 : (on_c ? 1'b1 : q.boiler);

  assign status = {24'h000000, grid, valve_tank, q.prohibit, q.ext_on, q.wp_en,
                   q.hp_en, q.boiler};

  assign wb_hit = i_wb_cyc && i_wb_stb && !q.ack;
  assign wb_wr  = wb_hit && i_wb_we;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d      = q;
    d.ack  = wb_hit;
    d.tick = 1'b0;

    if (q.sec_cnt == 28'(P_SEC_CYCLES - 1)) begin
      d.sec_cnt = 28'h0000000;
      d.tick    = 1'b1;
    end else begin
      d.sec_cnt = q.sec_cnt + 28'h0000001;
    end

    // register access; unmapped addresses answer with zero
    if (wb_hit) begin
      case (i_wb_adr)
        bbc_pkg::ADDR_CTRL:     d.rdat = {21'h000000, q.ctrl};
        bbc_pkg::ADDR_THRESH:   d.rdat = {24'h000000, q.thresh};
        bbc_pkg::ADDR_HEAT_SET: d.rdat = {16'h0000, q.heat_set};
        bbc_pkg::ADDR_DELAY:    d.rdat = {8'h00, q.delay_set};
        bbc_pkg::ADDR_TEMPS:    d.rdat = {8'h00, q.temps};
        bbc_pkg::ADDR_WATER:    d.rdat = q.water;
        bbc_pkg::ADDR_STATUS:   d.rdat = status;
        default:                d.rdat = 32'h00000000;
      endcase
    end
    if (wb_wr) begin
      case (i_wb_adr)
        bbc_pkg::ADDR_CTRL: begin
          d.ctrl = 11'(bbc_merge({21'h000000, q.ctrl}, i_wb_dat, i_wb_sel));
        end
        bbc_pkg::ADDR_THRESH: begin
          d.thresh = bbc_clamp(8'(bbc_merge({24'h000000, q.thresh}, i_wb_dat,
                                            i_wb_sel)));
        end
        bbc_pkg::ADDR_HEAT_SET: begin
          d.heat_set = 16'(bbc_merge({16'h0000, q.heat_set}, i_wb_dat, i_wb_sel));
        end
        bbc_pkg::ADDR_DELAY: begin
          d.delay_set = 24'(bbc_merge({8'h00, q.delay_set}, i_wb_dat, i_wb_sel));
        end
        bbc_pkg::ADDR_TEMPS: begin
          d.temps = 24'(bbc_merge({8'h00, q.temps}, i_wb_dat, i_wb_sel));
        end
        bbc_pkg::ADDR_WATER: begin
          d.water = bbc_merge(q.water, i_wb_dat, i_wb_sel);
        end
        default: begin
        end
      endcase
    end

    // over-temperature prohibit with fixed hold; a new start wins over expiry
    case (q.prh_st)
      bbc_pkg::PRH_IDLE: begin
        if (any_hot) begin
          d.prohibit = 1'b1;
          d.hold_cnt = 16'h0000;
          d.prh_st   = bbc_pkg::PRH_HOLD;
        end
      end
      bbc_pkg::PRH_HOLD: begin
        if (q.tick) begin
          if (q.hold_cnt == bbc_pkg::HOLD_S - 16'h0001) begin
            d.hold_cnt = 16'h0000;
            if (!any_hot) begin
              d.prohibit = 1'b0;
              d.prh_st   = bbc_pkg::PRH_IDLE;
            end
          end else begin
            d.hold_cnt = q.hold_cnt + 16'h0001;
          end
        end
      end
      default: begin
        d.prohibit = 1'b0;
        d.hold_cnt = 16'h0000;
        d.prh_st   = bbc_pkg::PRH_IDLE;
      end
    endcase

    // outputs
    if (pat_grid) begin
      d.boiler = grid[1] && !q.prohibit;
      d.hp_en  = grid[0];
      d.wp_en  = grid[0];
    end else if (!active) begin
      d.boiler = 1'b0;
      d.hp_en  = 1'b1;
      d.wp_en  = 1'b1;
    end else begin
      d.boiler = boiler_nxt;
      d.hp_en  = (sub == bbc_pkg::SUB_ALT) ? !boiler_nxt : 1'b1;
      d.wp_en  = (sub == bbc_pkg::SUB_ALT) ? !boiler_nxt : 1'b1;
    end
    d.ext_on    = ext_en && d.boiler;
    d.grid_dflt = pat_grid ? 2'h0 : grid;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.ctrl      <= bbc_pkg::CTRL_RST;
      q.thresh    <= bbc_pkg::THRESH_RST;
      q.heat_set  <= bbc_pkg::HEAT_SET_RST;
      q.delay_set <= bbc_pkg::DELAY_RST;
      q.temps     <= bbc_pkg::TEMPS_RST;
      q.water     <= bbc_pkg::WATER_RST;
      q.prh_st    <= bbc_pkg::PRH_IDLE;
      q.hp_en     <= 1'b1;
      q.wp_en     <= 1'b1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_wb_ack        = q.ack;
  assign o_wb_dat        = q.rdat;
  assign o_boiler_on     = q.boiler;
  assign o_heat_pump_en  = q.hp_en;
  assign o_water_pump_en = q.wp_en;
  assign o_ext_pump_on   = q.ext_on;
  assign o_prohibit      = q.prohibit;
  assign o_grid_default  = q.grid_dflt;

endmodule : bbc_boiler_ctrl

//--- dv/bbc_boiler_ctrl_properties.sv
// port-level checks of the boiler bivalent control block
// assumes a wishbone master that holds each request until its ack edge
module bbc_boiler_ctrl_chk #(
  parameter int unsigned P_SEC_CYCLES = 10
) (
  input wire logic        i_ref_clk,
  input wire logic        i_arst_n,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_boiler_on,
  input wire logic        o_heat_pump_en,
  input wire logic        o_water_pump_en,
  input wire logic        o_ext_pump_on,
  input wire logic        o_prohibit,
  input wire logic [1:0]  o_grid_default
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOT_LO  = 298 * P_SEC_CYCLES;
  localparam int HOLD_LO = 1799 * P_SEC_CYCLES;
  localparam logic [7:0] T = bbc_pkg::OVER_TEMP;
  logic [10:0] ctrl_q;
  logic        hot_q;
  int          hot_cnt_q;
  int          prh_cnt_q;
  logic        wr;
  logic        auto_on;
  assign wr = i_wb_stb && i_wb_we && o_wb_ack;
  assign auto_on = !ctrl_q[0] && ctrl_q[4] && (ctrl_q[7:5] <= 3'h2);
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= 11'h000;
      hot_q <= 1'b0;
      hot_cnt_q <= 0;
      prh_cnt_q <= 0;
    end else begin
      if (wr && i_wb_adr == bbc_pkg::ADDR_CTRL) ctrl_q <= i_wb_dat[10:0];
      if (wr && i_wb_adr == bbc_pkg::ADDR_WATER) hot_q <= (i_wb_dat[7:0] >= T) ||
        (i_wb_dat[15:8] >= T) || (i_wb_dat[23:16] >= T) || (i_wb_dat[31:24] >= T);
      hot_cnt_q <= hot_q ? hot_cnt_q + 1 : 0;
      prh_cnt_q <= o_prohibit ? prh_cnt_q + 1 : 0;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  property p_ext; o_ext_pump_on |-> o_boiler_on; endproperty
  a_ext: assert property (p_ext) else $error("ext pump on without boiler");
  property p_pumps; o_heat_pump_en == o_water_pump_en; endproperty
  a_pumps: assert property (p_pumps) else $error("pump enables differ");
  property p_alt; (auto_on && ctrl_q[2:1] == 2'h0)[*3] |-> o_boiler_on != o_heat_pump_en; endproperty
  a_alt: assert property (p_alt) else $error("alternative runs two sources");
  property p_par; (auto_on && ctrl_q[2:1] == 2'h1)[*3] |-> o_heat_pump_en; endproperty
  a_par: assert property (p_par) else $error("parallel stopped heat pump");
  property p_idle; (!ctrl_q[0] && !auto_on)[*3] |-> !o_boiler_on; endproperty
  a_idle: assert property (p_idle) else $error("boiler on while inactive");
  property p_grid; ctrl_q[0][*8] |-> o_grid_default == 2'h0; endproperty
  a_grid: assert property (p_grid) else $error("grid input kept default use");
  property p_th; (i_wb_stb && !i_wb_we && o_wb_ack && i_wb_adr == bbc_pkg::ADDR_THRESH) |->
    ($signed(o_wb_dat[7:0]) >= $signed(bbc_pkg::TH_MIN) &&
     $signed(o_wb_dat[7:0]) <= $signed(bbc_pkg::TH_MAX)); endproperty
  a_th: assert property (p_th) else $error("threshold out of range");
  property p_prh_set; $rose(o_prohibit) |-> hot_cnt_q >= HOT_LO; endproperty
  a_prh_set: assert property (p_prh_set) else $error("prohibit set too early");
  property p_prh_hold; $fell(o_prohibit) |-> prh_cnt_q >= HOLD_LO; endproperty
  a_prh_hold: assert property (p_prh_hold) else $error("prohibit cleared too early");
  property p_prh_off; o_prohibit[*3] |-> !o_boiler_on; endproperty
  a_prh_off: assert property (p_prh_off) else $error("boiler on while prohibited");
endmodule : bbc_boiler_ctrl_chk

bind bbc_boiler_ctrl bbc_boiler_ctrl_chk #(.P_SEC_CYCLES(P_SEC_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .o_boiler_on(o_boiler_on), .o_heat_pump_en(o_heat_pump_en),
  .o_water_pump_en(o_water_pump_en), .o_ext_pump_on(o_ext_pump_on),
  .o_prohibit(o_prohibit), .o_grid_default(o_grid_default));

//--- dv/bbc_boiler_model.sv
// behavioural auxiliary boiler with its external pump
// assumes the on/off request is a level on the block's clock
module bbc_boiler_model (
  input  wire logic i_ref_clk,
  input  wire logic i_boiler_on,
  input  wire logic i_ext_pump_on,
  output int        o_starts,
  output int        o_dry
);
  timeunit 1ns;
  timeprecision 1ps;
  logic on_q = 1'b0;
  // the boiler sees only an on/off request and runs its own settings
  always @(posedge i_ref_clk) begin
    on_q <= i_boiler_on;
    if (i_boiler_on && !on_q) o_starts <= o_starts + 1;
    if (i_ext_pump_on && !i_boiler_on) o_dry <= o_dry + 1;
  end
endmodule : bbc_boiler_model

//--- dv/tb_top.sv
// self-checking bench of the boiler bivalent control block
// assumes a one-cycle wishbone ack and a shortened seconds tick
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SEC = 2;
  // rows: ctrl, outdoor, grid pins, {ext, water pump, heat pump, boiler}
  localparam logic [25:0] ROWS [16] = '{
    {12'h018, 8'h03, 2'h2, 4'h9}, {12'h018, 8'h06, 2'h2, 4'h9}, {12'h018, 8'h08, 2'h2, 4'h6},
    {12'h018, 8'h06, 2'h2, 4'h6}, {12'h018, 8'h05, 2'h2, 4'h6}, {12'h01A, 8'h03, 2'h2, 4'hF},
    {12'h01A, 8'h08, 2'h2, 4'h6}, {12'h00A, 8'h03, 2'h2, 4'h6}, {12'h07A, 8'h03, 2'h2, 4'h6},
    {12'h03A, 8'h03, 2'h2, 4'hF}, {12'h058, 8'h03, 2'h2, 4'h9}, {12'h009, 8'h03, 2'h0, 4'h0},
    {12'h009, 8'h03, 2'h2, 4'h9}, {12'h009, 8'h03, 2'h1, 4'h6}, {12'h009, 8'h03, 2'h3, 4'hF},
    {12'h001, 8'h03, 2'h2, 4'h1}};
  localparam logic [15:0] TH [3] = '{16'h140F, 16'hE0F1, 16'h0505};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [1:0]  grid = 2'h0;
  logic        valve = 1'b0;
  logic        ack, boiler, hp, wp, ext, prh;
  logic [31:0] rdat, rd;
  logic [1:0]  gdef;
  logic [25:0] r;
  int          starts, dry;
  int          err_total = 0;
  int          checked = 0;
  always #2 clk = ~clk;
  bbc_boiler_ctrl #(.P_SEC_CYCLES(SEC)) dut (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .i_grid_signal_input(grid), .i_valve_tank(valve), .o_wb_ack(ack), .o_wb_dat(rdat),
    .o_boiler_on(boiler), .o_heat_pump_en(hp), .o_water_pump_en(wp), .o_ext_pump_on(ext),
    .o_prohibit(prh), .o_grid_default(gdef));
  bbc_boiler_model u_boiler (
    .i_ref_clk(clk), .i_boiler_on(boiler), .i_ext_pump_on(ext), .o_starts(starts), .o_dry(dry));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({prh, ext, wp, hp, boiler}, 5'h06, "reset outputs");
    wb(1'b0, bbc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'(bbc_pkg::CTRL_RST), "ctrl reset");
    wb(1'b0, bbc_pkg::ADDR_STATUS, 32'h0);
    chk(rd[5:0], 6'h06, "status reset");
    $display("reset test done");
  endtask : do_reset
  initial begin
    #240_000;
    err_total++;
    stop_test();
  end
  initial begin
    do_reset();
    wb(1'b1, bbc_pkg::ADDR_STATUS, 32'hFF);
    wb(1'b0, bbc_pkg::ADDR_STATUS, 32'h0);
    chk(rd[5:0], 6'h06, "status read only");
    wb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    foreach (TH[i]) begin
      wb(1'b1, bbc_pkg::ADDR_THRESH, {24'h0, TH[i][15:8]});
      wb(1'b0, bbc_pkg::ADDR_THRESH, 32'h0);
      chk(rd, {24'h0, TH[i][7:0]}, "threshold");
    end
    $display("register test done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(posedge clk);
      grid <= r[5:4];
      wb(1'b1, bbc_pkg::ADDR_CTRL, {20'h0, r[25:14]});
      wb(1'b1, bbc_pkg::ADDR_TEMPS, {24'h0, r[13:6]});
      repeat (8) @(posedge clk);
      chk({ext, wp, hp, boiler}, r[3:0], "outputs");
      chk(gdef, r[14] ? 2'h0 : r[5:4], "grid default");
      wb(1'b0, bbc_pkg::ADDR_STATUS, 32'h0);
      chk(rd[7:0], {r[5:4], 2'b00, r[3:0]}, "status");
      $display("row %0d done", i);
    end
    wb(1'b1, bbc_pkg::ADDR_HEAT_SET, 32'h0000_0502);
    wb(1'b1, bbc_pkg::ADDR_DELAY, 32'h0001_0001);
    wb(1'b1, bbc_pkg::ADDR_TEMPS, 32'h002A_3003);
    wb(1'b1, bbc_pkg::ADDR_CTRL, 32'h51C);
    repeat (8) @(posedge clk);
    chk(boiler, 1'b0, "adv buffer warm");
    wb(1'b1, bbc_pkg::ADDR_TEMPS, 32'h002A_2803);
    repeat (100) @(posedge clk);
    chk(boiler, 1'b0, "adv start delay");
    repeat (50) @(posedge clk);
    chk({ext, hp, boiler}, 3'h7, "adv heat on");
    valve <= 1'b1;
    repeat (8) @(posedge clk);
    chk(boiler, 1'b0, "adv left room");
    wb(1'b1, bbc_pkg::ADDR_CTRL, 32'h73C);
    repeat (80) @(posedge clk);
    chk(boiler, 1'b0, "adv tank delay");
    repeat (70) @(posedge clk);
    chk(boiler, 1'b1, "adv tank on");
    valve <= 1'b0;
    repeat (8) @(posedge clk);
    chk(boiler, 1'b0, "adv tank off");
    $display("advanced test done");
    wb(1'b1, bbc_pkg::ADDR_CTRL, 32'h018);
    wb(1'b1, bbc_pkg::ADDR_TEMPS, 32'h03);
    wb(1'b1, bbc_pkg::ADDR_WATER, 32'h5500_0000);
    repeat (560) @(posedge clk);
    chk({prh, boiler}, 2'h1, "prohibit qualify");
    repeat (60) @(posedge clk);
    chk({prh, hp, boiler}, 3'h6, "prohibit set");
    wb(1'b1, bbc_pkg::ADDR_WATER, 32'h0);
    repeat (3400) @(posedge clk);
    chk(prh, 1'b1, "prohibit hold");
    repeat (250) @(posedge clk);
    chk({prh, boiler}, 2'h1, "prohibit clear");
    chk(dry, 0, "ext pump alone");
    chk(starts != 0, 1'b1, "boiler starts");
    $display("prohibit test done");
    ce <= 1'b0;
    grid <= 2'h1;
    repeat (12) @(posedge clk);
    chk(gdef, 2'h2, "ce freeze");
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk(gdef, 2'h1, "ce resume");
    do_reset();
    stop_test();
  end
endmodule : tb_top
